// ==== lal_pkg.sv ====
// Shared constants and types for the low-level analog latch
package lal_pkg;
  localparam int LAL_DATA_W = 16;
  localparam logic [15:0] LAL_RESET_VAL = 16'h0000;
  // Enable source selection
  localparam logic [1:0] LAL_EN_SIGNAL = 2'h0;
  localparam logic [1:0] LAL_EN_ALWAYS_ON = 2'h1;
  localparam logic [1:0] LAL_EN_ALWAYS_OFF = 2'h2;
  // Trigger source selection
  localparam logic [1:0] LAL_TRG_CONST = 2'h0;
  localparam logic [1:0] LAL_TRG_DIG_IN = 2'h1;
  localparam logic [1:0] LAL_TRG_VIRT_OUT = 2'h2;
  localparam logic [1:0] LAL_TRG_NESTED = 2'h3;
  typedef logic [LAL_DATA_W-1:0] lal_word_t;
endpackage : lal_pkg

// ==== lal_latch.sv ====
// Low-level analog latch: pass while trigger high, hold while low
// Notes on behaviour
// - Enabled and trigger 1: output follows the present analog input.
// - Enabled trigger fall 1 to 0 captures the present analog input.
// - Trigger held at 0: output keeps the captured value.
// - Input, held value and output are one 16-bit word.
// - Value carried as raw bits, signedness never interpreted.
// - Disabled: output frozen at its value when disabling occurred.
// - On enable, resume at once from the latest inputs.
// - Enable is a signal, or constant always on or always off.
// - Trigger from constant, digital input, virtual output or nested block.
`timescale 1ns/1ns
module lal_latch
  import lal_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [1:0] en_sel,
  input wire logic en_in,
  input wire logic [1:0] trg_sel,
  input wire logic trg_const,
  input wire logic trg_dig_in,
  input wire logic trg_virt_out,
  input wire logic trg_nested,
  input wire lal_word_t analog_in,
  output lal_word_t latch_out,
  output logic active
);
  lal_word_t out_q;
  lal_word_t out_d;
  logic trg_q;
  logic trg_d;
  logic en_eff;
  logic trg_eff;
  logic trg_fall;

  // Decode of enable source
  always_comb
  begin
    case (en_sel)
      LAL_EN_SIGNAL: en_eff = en_in;
      LAL_EN_ALWAYS_ON: en_eff = 1'b1;
      LAL_EN_ALWAYS_OFF: en_eff = 1'b0;
      default: en_eff = 1'b0;
    endcase
  end

  // Decode of trigger source
  always_comb
  begin
    case (trg_sel)
      LAL_TRG_CONST: trg_eff = trg_const;
      LAL_TRG_DIG_IN: trg_eff = trg_dig_in;
      LAL_TRG_VIRT_OUT: trg_eff = trg_virt_out;
      LAL_TRG_NESTED: trg_eff = trg_nested;
      default: trg_eff = 1'b0;
    endcase
  end

  // Falling trigger: history says 1, present sample says 0
  assign trg_fall = trg_q && !trg_eff;

  // Trigger history, sampled even while disabled
  always_comb
  begin
    trg_d = trg_eff;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      trg_q <= 1'b0;
    else if (clk_en)
      trg_q <= trg_d;
  end

  // Output word: pass at level 1, capture at the fall, else keep
  always_comb
  begin
    out_d = out_q;
    if (en_eff)
    begin
      if (trg_eff)
        out_d = analog_in;
      else if (trg_fall)
        out_d = analog_in;
    end // Holding at 0, or disabled: keep value
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      out_q <= LAL_RESET_VAL;
    else if (clk_en)
      out_q <= out_d;
  end

  assign latch_out = out_q;
  assign active = en_eff;

  a_pass_high: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && en_eff && trg_eff |=> latch_out == $past(analog_in))
    else $error("output did not follow input while trigger high");

  a_capture_fall: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && en_eff && trg_fall |=> latch_out == $past(analog_in))
    else $error("falling trigger did not capture input");

  a_fall_once: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && trg_fall |=> !trg_fall)
    else $error("one fall seen twice");

  a_hold_low: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && en_eff && !trg_eff && !trg_q |=> $stable(latch_out))
    else $error("held value changed while trigger low");

  a_low_ignores: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && en_eff && !trg_eff && !trg_q && $changed(analog_in)
    |=> $stable(latch_out))
    else $error("input change leaked through while trigger low");

  a_raw_bits: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && en_eff && (trg_eff || trg_q) && analog_in == 16'h8000
    |=> latch_out == 16'h8000)
    else $error("bit pattern altered");

  a_raw_max: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && en_eff && trg_eff && analog_in == 16'hffff
    |=> latch_out == 16'hffff)
    else $error("all-ones pattern altered");

  a_freeze_off: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !en_eff |=> $stable(latch_out))
    else $error("output changed while disabled");

  a_off_observe: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && !en_eff |=> trg_q == $past(trg_eff))
    else $error("trigger not observed while disabled");

  a_resume_on: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && !$past(en_eff) && en_eff && trg_eff
    |=> latch_out == $past(analog_in))
    else $error("no pass-through right after enabling");

  a_resume_fall: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && !$past(en_eff) && en_eff && trg_fall
    |=> latch_out == $past(analog_in))
    else $error("no capture of a fall seen at enabling");

  a_resume_hold: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && !$past(en_eff) && en_eff && !trg_eff && !trg_q
    |=> $stable(latch_out))
    else $error("frozen value lost at enabling with trigger low");

  a_force_off: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    en_sel == LAL_EN_ALWAYS_OFF |-> !active)
    else $error("always-off enable still active");

  a_force_on: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    en_sel == LAL_EN_ALWAYS_ON |-> active)
    else $error("always-on enable not active");

  a_en_signal: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    en_sel == LAL_EN_SIGNAL |-> active == en_in)
    else $error("signal enable not followed");

  a_spare_off: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    en_sel == 2'h3 |-> !active)
    else $error("spare enable setting not disabled");

  a_trg_const: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    trg_sel == LAL_TRG_CONST |-> trg_eff == trg_const)
    else $error("constant trigger source not selected");

  a_trg_dig: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    trg_sel == LAL_TRG_DIG_IN |-> trg_eff == trg_dig_in)
    else $error("digital input trigger source not selected");

  a_trg_virt: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    trg_sel == LAL_TRG_VIRT_OUT |-> trg_eff == trg_virt_out)
    else $error("virtual output trigger source not selected");

  a_trg_nested: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    trg_sel == LAL_TRG_NESTED |-> trg_eff == trg_nested)
    else $error("nested trigger source not selected");

  a_reset_zero: assert property (
    @(posedge core_clk)
    sys_rst |=> latch_out == LAL_RESET_VAL)
    else $error("reset did not clear output");

  a_reset_hist: assert property (
    @(posedge core_clk)
    sys_rst |=> !trg_q)
    else $error("reset did not clear trigger history");

  a_trg_history: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    clk_en |=> trg_q == $past(trg_eff))
    else $error("trigger history missed a sample");

  a_clken_hold: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !clk_en |=> $stable(latch_out))
    else $error("output changed with clock enable low");

  a_clken_hist: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !clk_en |=> $stable(trg_q))
    else $error("trigger history changed with clock enable low");
endmodule : lal_latch

// ==== lal_src.sv ====
// Source model for the trigger candidates of the latch
`timescale 1ns/1ns
module lal_src
  import lal_pkg::*;
(
  input wire logic [1:0] sel,
  input wire logic trg,
  output logic [3:0] trg_o
);
  // Unselected sources show the inverse level
  always_comb
  begin
    trg_o = {4{~trg}};
    trg_o[sel] = trg;
  end
endmodule : lal_src

// ==== low_level_analog_latch_tb.sv ====
// Testbench for the low-level analog latch
`timescale 1ns/1ns
module low_level_analog_latch_tb;
  import lal_pkg::*;
  logic core_clk = 0, sys_rst = 1, ei = 0, t = 0, ce = 1, act;
  logic [1:0] es = 0, ts = 0;
  logic [3:0] tv;
  lal_word_t a = 0, q;
  int mismatches = 0, n_compared = 0;
  // en_sel, en_in, trg_sel, trigger, input, expected output
  logic [37:0] rows [10] = '{
    {2'h0, 1'h1, 2'h0, 1'h1, 16'h1234, 16'h1234},
    {2'h0, 1'h1, 2'h0, 1'h0, 16'h5678, 16'h5678},
    {2'h0, 1'h1, 2'h0, 1'h0, 16'h1111, 16'h5678},
    {2'h0, 1'h1, 2'h1, 1'h1, 16'hffff, 16'hffff},
    {2'h0, 1'h1, 2'h2, 1'h0, 16'h8000, 16'h8000},
    {2'h0, 1'h1, 2'h3, 1'h1, 16'h0042, 16'h0042},
    {2'h2, 1'h1, 2'h3, 1'h1, 16'h7777, 16'h0042},
    {2'h3, 1'h1, 2'h3, 1'h1, 16'h2222, 16'h0042},
    {2'h1, 1'h0, 2'h3, 1'h1, 16'h3333, 16'h3333},
    {2'h0, 1'h0, 2'h3, 1'h1, 16'h4444, 16'h3333}};
  always #4 core_clk = ~core_clk;
  lal_src lal_src_i (.sel(ts), .trg(t), .trg_o(tv));
  lal_latch lal_latch_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .clk_en(ce), .en_sel(es), .en_in(ei), .trg_sel(ts),
    .trg_const(tv[0]), .trg_dig_in(tv[1]), .trg_virt_out(tv[2]),
    .trg_nested(tv[3]), .analog_in(a), .latch_out(q), .active(act));
  task automatic chk(input string n, input lal_word_t s, input lal_word_t e);
    n_compared++;
    if (s !== e)
      $display("BAD %s exp %h seen %h", n, e, s);
    mismatches += int'(s !== e);
  endtask : chk
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1 chk("latch_out", q, 16'h0000);
    $display("reset test done");
    foreach (rows[i])
    begin
      @(posedge core_clk);
      {es, ei, ts, t, a} <= rows[i][37:16];
      @(posedge core_clk);
      #1 chk("latch_out", q, rows[i][15:0]);
    end
    $display("row tests done");
    // Clock enable low freezes output and trigger history
    @(posedge core_clk);
    {ce, es, t, a} <= {1'b0, 2'h1, 1'b0, 16'h9abc};
    @(posedge core_clk);
    #1 chk("latch_out", q, 16'h3333);
    chk("active", {15'h0, act}, 16'h0001);
    @(posedge core_clk);
    {ce, a} <= {1'b1, 16'h5a5a};
    @(posedge core_clk);
    #1 chk("latch_out", q, 16'h5a5a);
    $display("clock enable test done");
    // Fall seen at the enabling edge captures at once
    @(posedge core_clk);
    {es, ei, t, a} <= {2'h0, 1'b0, 1'b1, 16'h1357};
    @(posedge core_clk);
    #1 chk("latch_out", q, 16'h5a5a);
    chk("active", {15'h0, act}, 16'h0000);
    @(posedge core_clk);
    {ei, t, a} <= {1'b1, 1'b0, 16'h2468};
    @(posedge core_clk);
    #1 chk("latch_out", q, 16'h2468);
    $display("enable at fall test done");
    // Fall wholly inside a disabled stretch keeps the frozen value
    @(posedge core_clk);
    {ei, t, a} <= {1'b0, 1'b1, 16'h1111};
    repeat (2) @(posedge core_clk);
    t <= 1'b0;
    repeat (2) @(posedge core_clk);
    {ei, a} <= {1'b1, 16'h2222};
    @(posedge core_clk);
    #1 chk("latch_out", q, 16'h2468);
    $display("enable after fall test done");
    // Reset in mid-run
    @(posedge core_clk);
    {sys_rst, t, a} <= {1'b1, 1'b1, 16'h7e7e};
    @(posedge core_clk);
    #1 chk("latch_out", q, 16'h0000);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    #1 chk("latch_out", q, 16'h0000);
    @(posedge core_clk);
    #1 chk("latch_out", q, 16'h7e7e);
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule : low_level_analog_latch_tb
